// [verilog/sub_pkg.sv]
// Purpose: Shared constants and types for the subtract instruction unit
// Assumes: 32-bit AHB-Lite register access, byte addresses, word aligned
// Notes: Flag positions follow the core status byte layout
package sub_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_INSTR = 12'h000;
    localparam logic [11:0] OFF_ACC = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_BANK_SEL = 12'h00C;
    localparam logic [11:0] OFF_CTRL = 12'h010;
    localparam logic [11:0] OFF_INDEX_BASE = 12'h014;
    localparam logic [11:0] OFF_LAST_ADDR = 12'h018;
    // File memory window: word i at 0x040 + 4*i
    localparam logic [5:0] MEM_WINDOW = 6'h01;

    // Status and control field positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DIGIT_CARRY = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OVERFLOW = 3;
    localparam int FLAG_N = 4;
    localparam int STAT_BUSY = 7;
    localparam int CTRL_EXT_EN = 0;

    // Reset values
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [11:0] RST_INDEX_BASE = 12'h000;

    // Opcode patterns
    localparam logic [7:0] OPC_LIT = 8'h08;
    localparam logic [5:0] OPC_FILE = 6'h17;
    localparam logic [5:0] OPC_BORROW = 6'h15;

    // Addressing limits
    localparam logic [7:0] MAX_INDEXED = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // Instruction kinds
    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_LIT,
        KIND_FILE,
        KIND_BORROW
    } kind_e;

    // Decoded instruction word
    typedef struct packed {
        kind_e kind;
        logic dest;
        logic access;
        logic [7:0] field;
    } instr_s;

    // Captured AHB address phase
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
    } ahb_ap_s;

    // Result flags of the subtractor
    typedef struct packed {
        logic n;
        logic overflow;
        logic z;
        logic digit_carry;
        logic c;
    } flags_s;

endpackage

// [verilog/sub_alu.sv]
// Purpose: 8-bit subtractor a - b - !carry_in with status flags
// Assumes: Purely combinational, used once per instruction cycle
// Notes: Carry is the inverted borrow, as the core expects
`timescale 1ns/1ps
module sub_alu
    import sub_pkg::*;
(
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic carry_in,
    // Results
    output logic [7:0] result,
    output flags_s flags
);
    // Add the complement so the 9-bit adder yields the carry; a separate nibble sum gives digit carry
    wire logic [8:0] full = {1'b0, a} + {1'b0, ~b} + {8'h00, carry_in};
    // Low nibble sum, bit 4 is the digit carry
    wire logic [4:0] low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, carry_in};

    assign result = full[7:0];
    assign flags.c = full[8];
    assign flags.digit_carry = low[4];
    // zero only for a zero result
    assign flags.z = (full[7:0] == 8'h00);
    assign flags.n = full[7];
    // Overflow: signs of operands differ and result sign leaves a
    assign flags.overflow = (a[7] != b[7]) && (full[7] != a[7]);
endmodule

// [verilog/subtract_instruction_unit.sv]
// Purpose: Decode and execute the three subtract instructions over AHB-Lite
// Assumes: Single clock, synchronous active-high reset, zero-wait writes
// Notes: One instruction runs through four phases after its launch
`timescale 1ns/1ps
module subtract_instruction_unit
    import sub_pkg::*;
#(
    parameter int MEM_DEPTH = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    localparam int MEM_AW = $clog2(MEM_DEPTH);
    // Instruction phase sequencer states
    typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;
    // Decode an instruction word into kind and fields
    function automatic instr_s decode_instr(input logic [15:0] w);
        instr_s d;
        d = '{kind: KIND_NONE, dest: w[9], access: w[8], field: w[7:0]};
        if (w[15:8] == OPC_LIT)
            d.kind = KIND_LIT;
        else if (w[15:10] == OPC_FILE)
            d.kind = KIND_FILE;
        else if (w[15:10] == OPC_BORROW)
            d.kind = KIND_BORROW;
        return d;
    endfunction
    // Resolve the 12-bit data address of a file operand
    function automatic logic [11:0] file_addr(input logic [7:0] f, input logic acc_bit,
        input logic [3:0] bank, input logic ext, input logic [11:0] base);
        if (!acc_bit && ext && f <= MAX_INDEXED)
            return base + {4'h0, f};
        else if (!acc_bit)
            return (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HIGH_BANK, f};
        else
            return {bank, f};
    endfunction
    // Software visible state
    logic [7:0] acc_q;              // Working accumulator
    flags_s status_q; // Negative, overflow, zero, digit carry, carry
    logic [3:0] bank_select_register_q;
    logic ext_en_q;                 // Extended instruction set enable
    logic [11:0] index_base_q;      // Base for indexed literal offset
    logic [7:0] mem_q [MEM_DEPTH];  // File register storage
    // Execution state
    phase_e phase_q;
    instr_s ins_q;                  // Instruction in flight
    logic [11:0] addr_q;            // Resolved file address
    logic [7:0] op_q;               // Operand read in Q2
    logic [7:0] res_q;              // Result formed in Q3
    flags_s flags_q;                // Flags formed in Q3
    // Bus state
    ahb_ap_s ap_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    // Address phase acceptance, only NONSEQ or SEQ with hready
    wire logic take = hsel && htrans[1] && hready;
    wire logic wr_acc = ap_q.wr && ap_q.addr == OFF_ACC;
    wire logic wr_stat = ap_q.wr && ap_q.addr == OFF_STATUS;
    wire logic wr_instr = ap_q.wr && ap_q.addr == OFF_INSTR;
    wire logic in_mem = ap_q.addr[11:6] == MEM_WINDOW;
    wire logic wr_mem = ap_q.wr && in_mem;
    wire logic [MEM_AW-1:0] bus_idx = ap_q.addr[2 +: MEM_AW];
    wire logic [MEM_AW-1:0] exec_idx = addr_q[MEM_AW-1:0];
    wire instr_s dec = decode_instr(hwdata[15:0]);
    // A write while busy or of a foreign opcode launches nothing
    wire logic launch = wr_instr && phase_q == PH_IDLE && dec.kind != KIND_NONE;
    // destination select, literal always targets the accumulator
    wire logic to_acc = ins_q.kind == KIND_LIT || !ins_q.dest;
    wire logic is_borrow = ins_q.kind == KIND_BORROW;
    // operand order: borrow form subtracts the file from the accumulator
    wire logic [7:0] alu_a = is_borrow ? acc_q : op_q;
    wire logic [7:0] alu_b = is_borrow ? op_q : acc_q;
    wire logic alu_cin = is_borrow ? status_q.c : 1'b1;
    wire logic [7:0] alu_res;
    wire flags_s alu_flags;
    // Subtractor shared by all three forms
    sub_alu u_alu (
        .a(alu_a),
        .b(alu_b),
        .carry_in(alu_cin),
        .result(alu_res),
        .flags(alu_flags)
    );
    // Read data mux, unmapped words read zero
    wire logic [7:0] stat_rd = {phase_q != PH_IDLE, 2'b00, status_q};
    wire logic [31:0] rd_word =
        ap_q.addr == OFF_ACC ? {24'h0, acc_q} :
        ap_q.addr == OFF_STATUS ? {24'h0, stat_rd} :
        ap_q.addr == OFF_BANK_SEL ? {28'h0, bank_select_register_q} :
        ap_q.addr == OFF_CTRL ? {31'h0, ext_en_q} :
        ap_q.addr == OFF_INDEX_BASE ? {20'h0, index_base_q} :
        ap_q.addr == OFF_LAST_ADDR ? {20'h0, addr_q} :
        in_mem ? {24'h0, mem_q[bus_idx]} : 32'h0000_0000;
    // Bus phases: reads take one wait state so data reflects prior writes
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ap_q <= '0;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            ap_q <= take ? ahb_ap_s'{wr: hwrite, rd: !hwrite, addr: haddr[11:0]} : '0;
            // Stall only the data phase of a read
            hreadyout_q <= !(take && !hwrite);
            if (ap_q.rd)
                hrdata_q <= rd_word;
        end
    end
    // Plain control registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bank_select_register_q <= RST_BANK;
            ext_en_q <= 1'b0;
            index_base_q <= RST_INDEX_BASE;
        end
        else if (ap_q.wr)
        begin
            if (ap_q.addr == OFF_BANK_SEL)
                bank_select_register_q <= hwdata[3:0];
            if (ap_q.addr == OFF_CTRL)
                ext_en_q <= hwdata[CTRL_EXT_EN];
            if (ap_q.addr == OFF_INDEX_BASE)
                index_base_q <= hwdata[11:0];
        end
    end
    // phase sequencer, one instruction cycle of four phases
    always_ff @(posedge clk)
    begin
        if (reset)
            phase_q <= PH_IDLE;
        else
        begin
            case (phase_q)
                PH_IDLE: phase_q <= launch ? PH_Q1 : PH_IDLE;
                PH_Q1: phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                PH_Q4: phase_q <= PH_IDLE;
                default: phase_q <= PH_IDLE;
            endcase
        end
    end
    // Datapath registers per phase
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ins_q <= '0;
            addr_q <= 12'h000;
            op_q <= 8'h00;
            res_q <= 8'h00;
            flags_q <= '0;
        end
        else
        begin
            if (launch)
                ins_q <= dec;
            // Q1 decode: resolve the file address
            if (phase_q == PH_Q1)
                addr_q <= file_addr(ins_q.field, ins_q.access, bank_select_register_q,
                    ext_en_q, index_base_q);
            // Q2 read literal or file register
            if (phase_q == PH_Q2)
                op_q <= (ins_q.kind == KIND_LIT) ? ins_q.field : mem_q[exec_idx];
            if (phase_q == PH_Q3)
            begin
                res_q <= alu_res;
                flags_q <= alu_flags;
            end
        end
    end
    // accumulator write-back, Q4 wins over a bus write
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            acc_q <= RST_ACC;
            status_q <= RST_FLAGS;
        end
        else
        begin
            if (phase_q == PH_Q4 && to_acc)
                acc_q <= res_q;
            else if (wr_acc)
                acc_q <= hwdata[7:0];
            if (phase_q == PH_Q4)
                status_q <= flags_q;
            else if (wr_stat)
                status_q <= hwdata[4:0];
        end
    end
    // File storage; only the low address bits index this small array
    always_ff @(posedge clk)
    begin
        if (reset)
            for (int i = 0; i < MEM_DEPTH; i++)
                mem_q[i] <= 8'h00;
        else if (phase_q == PH_Q4 && !to_acc)
            // write back to the file register
            mem_q[exec_idx] <= res_q;
        else if (wr_mem)
            mem_q[bus_idx] <= hwdata[7:0];
    end
    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    // Helper checks for the assertions below
    wire logic [7:0] exp_fwb = acc_q - op_q - {7'h00, !status_q.c};
    wire logic exp_carry = {1'b0, alu_a} >= ({1'b0, alu_b} + {8'h00, !alu_cin});
    wire logic [7:0] exp_diff = alu_a - alu_b - {7'h00, !alu_cin}; // Plain difference
    sequence s_process;
        phase_q == PH_Q2 ##1 phase_q == PH_Q3 ##1 phase_q == PH_Q4;
    endsequence
    a_phase_walk: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q1 |=> s_process ##1 phase_q == PH_IDLE)
        else $error("phase sequence broken");
    a_lit_decode: assert property (@(posedge clk) disable iff (reset)
        launch && hwdata[15:8] == 8'h08 |=> ins_q.kind == KIND_LIT)
        else $error("literal opcode not decoded");
    a_lit_to_acc: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q4 && ins_q.kind == KIND_LIT |=> acc_q == $past(res_q))
        else $error("literal result not in accumulator");
    a_flags_commit: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q3 |-> ##2 status_q == $past(alu_flags, 2))
        else $error("flags not committed");
    a_file_decode: assert property (@(posedge clk) disable iff (reset)
        launch && hwdata[15:10] == 6'b01_0111 |=> ins_q.kind == KIND_FILE)
        else $error("file opcode not decoded");
    a_dest_acc: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q4 && ins_q.kind == KIND_FILE && !ins_q.dest && !wr_mem
        |=> mem_q[exec_idx] == $past(mem_q[exec_idx]) && acc_q == $past(res_q))
        else $error("dest 0 touched file");
    a_dest_file: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q4 && ins_q.kind != KIND_LIT && ins_q.dest
        |=> mem_q[exec_idx] == $past(res_q))
        else $error("dest 1 not written to file");
    a_bank_addr: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q1 && ins_q.access
        |=> addr_q == {$past(bank_select_register_q), ins_q.field})
        else $error("bank select address wrong");
    a_indexed: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q1 && !ins_q.access && ext_en_q && ins_q.field <= 8'h5F
        |=> addr_q == $past(index_base_q) + {4'h0, ins_q.field})
        else $error("indexed offset address wrong");
    a_carry_zero: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q3 |=> flags_q.c == $past(exp_carry) && flags_q.z == (res_q == 8'h00))
        else $error("carry or zero flag wrong");
    a_negative: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q3 |=> flags_q.n == $past(exp_diff[7]) && res_q == $past(exp_diff))
        else $error("negative flag wrong");
    a_borrow_form: assert property (@(posedge clk) disable iff (reset)
        phase_q == PH_Q3 && is_borrow |=> res_q == $past(exp_fwb))
        else $error("borrow subtract wrong");
endmodule

// [dv/tb_subtract_instruction_unit.sv]
// Purpose: Self-checking bench for the subtract instruction unit
// Assumes: One AHB-Lite slave, hready looped from hreadyout, word transfers
// Notes: An integer model of acc and flags is checked after each op, file memory after file and borrow ops
`timescale 1ns/1ps
module tb_subtract_instruction_unit;
    import sub_pkg::*;
    // Clock, reset and bus drive
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    // Counters and model state
    int bad_count = 0;
    int samples_checked = 0;
    int acc, flg, bank, ext, ibase;
    int mem [16];
    // Random source, fixed start
    logic [15:0] lfsr_q = 16'h0019;

    subtract_instruction_unit #(.MEM_DEPTH(16)) dut_u (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

    // Free running clock
    initial
    begin
        forever #2 clk = ~clk;
    end

    // Galois-free shift step; eight steps per draw to break correlation
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic rnd(output int v);
        repeat (8) lfsr_q = lfsr_next(lfsr_q);
        v = lfsr_q[7:0];
    endtask

    // One AHB transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [11:0] a, input int d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'(d);
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        xfer(1'b0, a, 0, r);
    endtask

    task automatic wr(input logic [11:0] a, input int d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input int exp);
        samples_checked++;
        if (got !== 32'(exp))
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, 32'(exp));
            bad_count++;
        end
    endtask

    // Model of a - b - !cin; carry is the inverted borrow
    task automatic model_sub(input int a, input int b, input int cin, output int r);
        int s;
        int dig;
        int ovf;
        s = a + (~b & 255) + cin;
        dig = ((a & 15) + (~b & 15) + cin) >> 4;
        r = s & 255;
        ovf = ((a ^ b) & (a ^ r)) >> 7 & 1;
        flg = ((r >> 7) << 4) | (ovf << 3) | ((r == 0) << 2) | (dig << 1) | (s >> 8);
    endtask

    // Load core state through the bus and mirror it in the model
    task automatic setup(input int w, input int c, input int b, input int e, input int ib);
        acc = w;
        flg = c;
        bank = b;
        ext = e;
        ibase = ib;
        wr(OFF_ACC, w);
        wr(OFF_STATUS, c);
        wr(OFF_BANK_SEL, b);
        wr(OFF_CTRL, e);
        wr(OFF_INDEX_BASE, ib);
    endtask

    // Launch one instruction (1 literal, 2 file, 3 borrow) and check results
    task automatic exec(input int kind, input int d, input int a, input int f);
        logic [31:0] r;
        int addr, idx, res, word;
        // Operand address as the addressing modes resolve it
        if (a)
            addr = (bank << 8) | f;
        else if (ext && f <= 95)
            addr = (ibase + f) & 4095;
        else if (f < 96)
            addr = f;
        else
            addr = 3840 | f;
        idx = addr & 15;
        word = ((kind == 2 ? 23 : 21) << 10) | (d << 9) | (a << 8) | f;
        if (kind == 1)
            word = (8 << 8) | f;
        wr(OFF_INSTR, word);
        rd(OFF_STATUS, r);
        chk({31'h0, r[7]}, 1);
        for (int i = 0; i < 8 && r[7] === 1'b1; i++)
            rd(OFF_STATUS, r);
        if (kind == 1)
        begin
            model_sub(f, acc, 1, res);
            acc = res;
        end
        else
        begin
            if (kind == 2)
                model_sub(mem[idx], acc, 1, res);
            else
                model_sub(acc, mem[idx], flg & 1, res);
            if (d)
                mem[idx] = res;
            else
                acc = res;
        end
        rd(OFF_ACC, r);
        chk(r, acc);
        rd(OFF_STATUS, r);
        chk(r, flg);
        if (kind != 1)
        begin
            rd(OFF_LAST_ADDR, r);
            chk(r, addr);
            rd(12'h040 + 12'(4 * idx), r);
            chk(r, mem[idx]);
        end
    endtask

    // Verdict, shared by the main sequence and the watchdog
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        int v [6];
        logic [31:0] r;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // Reset values; 0x01C is unmapped and must read zero
        for (int i = 0; i < 8; i++)
        begin
            rd(12'(4 * i), r);
            chk(r, 0);
        end
        // A foreign opcode of the 0101 10da form must launch nothing
        wr(OFF_INSTR, 32'h0000_5A00);
        rd(OFF_STATUS, r);
        chk(r, 0);
        chk({31'h0, hresp}, 0);
        // Random file memory contents
        for (int i = 0; i < 16; i++)
        begin
            rnd(v[0]);
            mem[i] = v[0];
            wr(12'h040 + 12'(4 * i), v[0]);
        end
        // Literal 2 against W of 1, 2, 3: positive, zero, wrapped
        for (int w = 1; w < 4; w++)
        begin
            setup(w, 0, 0, 0, 0);
            exec(1, 0, 0, 2);
        end
        // Indexed boundary at 95 and 96, then banked access
        setup(5, 1, 3, 1, 12'h0A0);
        exec(2, 1, 0, 95);
        exec(2, 1, 0, 96);
        exec(3, 0, 0, 95);
        exec(3, 1, 1, 95);
        // Random mix of all three forms and both bits
        repeat (40)
        begin
            foreach (v[i])
                rnd(v[i]);
            setup(v[0], v[1] & 31, v[2] & 15, v[3] & 1, (v[4] << 4) | v[2]);
            exec(v[4] % 3 + 1, v[3] >> 1 & 1, v[3] >> 2 & 1, v[5]);
        end
        end_of_test;
    end

    // Watchdog, far beyond the roughly 1400 cycles the run needs
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        end_of_test;
    end
endmodule
